//--- src/asr_pkg.sv
// Purpose: constants shared by the static memory controller
// Assumes: 100 MHz core clock, fastest speed grade of the memory
// Notes:   strobe width, access and gate-to-high-Z timings are converted to whole clock cycles here
package asr_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int unsigned INDEX_W = 17;
  localparam int unsigned BYTE_W  = 8;

  // ****************************************************************
  // timing in ns, and derived cycle counts
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INDEX_SETUP_TO_WRITE_END_NS = 8;
  localparam int unsigned INDEX_HOLD_AFTER_WRITE_END_NS = 0;
  localparam int unsigned DATA_SETUP_TO_WRITE_END_NS = 5;
  localparam int unsigned STROBE_WIDTH_GATE_LOW_NS = 10;
  localparam int unsigned STROBE_TO_BUS_RELEASE_NS = 5;
  localparam int unsigned INDEX_ACCESS_NS = 10;
  localparam int unsigned GATE_TO_HIGHZ_NS = 5;

  function automatic int unsigned ns_to_min_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // write strobe low time: covers index setup, data setup and gate-low width
  localparam int unsigned WR_LOW_CYC = ns_to_min_cycles(STROBE_WIDTH_GATE_LOW_NS);
  // read: one cycle for access, two more for the input synchroniser
  localparam int unsigned RD_WAIT_CYC = ns_to_min_cycles(INDEX_ACCESS_NS) + 2;
  // bus turnaround after gate rises, before controller drives
  localparam int unsigned TURN_CYC = ns_to_min_cycles(GATE_TO_HIGHZ_NS);

  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [5:0] {
    ASR_IDLE   = 6'h01,
    ASR_WSETUP = 6'h02,
    ASR_WLOW   = 6'h04,
    ASR_WEND   = 6'h08,
    ASR_RWAIT  = 6'h10,
    ASR_TURN   = 6'h20
  } asr_state_e;

endpackage

//--- src/asr_sync.sv
// Purpose: two-stage synchroniser for the returning byte lines
// Assumes: data is stable while captured (held by device after access)
// Notes:   first stage is read only by the second stage
module asr_sync (
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  input  wire logic [asr_pkg::BYTE_W-1:0] din,
  output logic      [asr_pkg::BYTE_W-1:0] dout
);
  import asr_pkg::*;

  typedef struct packed {
    logic [BYTE_W-1:0] s1;
    logic [BYTE_W-1:0] s2;
  } asr_sync_s;

  asr_sync_s st_reg;
  asr_sync_s st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.s2;
endmodule

//--- src/asr_ctrl.sv
// Purpose: controller driving an asynchronous 128K x 8 static memory
// Assumes: single request port, one access at a time, 100 MHz clock
// Notes:   writes are strobe-controlled with chip select held across them
//          write: select low with index and data, one cycle later strobe low for
//          the counted width, strobe rises to end the write, then select rises
//          read: select and gate low together with the index, the returning
//          byte passes the synchroniser and is taken after the counted wait
//          after a read one turnaround cycle lets the memory release the lines
//          gate stays high during writes so the memory never drives then
//          write data is held one cycle past the strobe rise, so no hold time
//          is asked of the memory; index may change with select rising
//
// What this block does
// - index, data, strobes valid before write start
// - write ends when select or strobe rises
// - data timing measured from write end edge
// - data stable 5 ns before write end
// - index stable 8 ns before write end
// - index may change right at write end
// - strobe low 10 ns when gate low
// - strobe stays high during every read
// - index valid by select falling edge
// - select and gate low: data per index
module asr_ctrl (
  input  wire logic                        core_clk,
  input  wire logic                        nrst,
  input  wire logic                        req_valid,
  input  wire logic                        req_write,
  input  wire logic [asr_pkg::INDEX_W-1:0] req_index,
  input  wire logic [asr_pkg::BYTE_W-1:0]  req_wdata,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic      [asr_pkg::BYTE_W-1:0]  rsp_rdata,
  output logic      [asr_pkg::INDEX_W-1:0] word_index,
  output logic      [asr_pkg::BYTE_W-1:0]  byte_lines_o,
  output logic                             byte_lines_oe,
  input  wire logic [asr_pkg::BYTE_W-1:0]  byte_lines_i,
  output logic                             select_n,
  output logic                             gate_n,
  output logic                             strobe_n
);
  import asr_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    asr_state_e          state;
    logic [CNT_W-1:0]    cnt;
    logic                ready;
    logic                rvalid;
    logic [BYTE_W-1:0]   rdata;
    logic [INDEX_W-1:0]  index;
    logic [BYTE_W-1:0]   wdata;
    logic                oe;
    logic                sel_n;
    logic                gate_n;
    logic                strb_n;
  } asr_ctrl_s;

  asr_ctrl_s         st_reg;
  asr_ctrl_s         st_next;
  logic [BYTE_W-1:0] rd_sync;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    return n[CNT_W-1:0];
  endfunction

  // true on the last cycle of a counted wait
  function automatic logic last_cycle(input logic [CNT_W-1:0] c);
    return c <= CNT_ONE;
  endfunction

  // counted waits step down by one each clock
  function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
    return c - CNT_ONE;
  endfunction

  // strobes inactive and byte lines released
  function automatic asr_ctrl_s park_pins(input asr_ctrl_s s);
    asr_ctrl_s p;
    p        = s;
    p.sel_n  = 1'b1;
    p.gate_n = 1'b1;
    p.strb_n = 1'b1;
    p.oe     = 1'b0;
    return p;
  endfunction

  // ****************************************************************
  // input synchroniser for read data
  // ****************************************************************
  asr_sync u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .din      (byte_lines_i),
    .dout     (rd_sync)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // one access at a time; req_ready is low from the taking edge until the
  // pins are back in standby, and after a read until the turnaround cycle ends,
  // so a new request never overlaps the last one
  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = 1'b0;
    case (st_reg.state)
      ASR_IDLE: begin
        st_next.sel_n  = 1'b1;
        st_next.gate_n = 1'b1;
        st_next.strb_n = 1'b1;
        st_next.oe     = 1'b0;
        st_next.ready  = 1'b1;
        if (st_reg.ready && req_valid) begin
          st_next.ready = 1'b0;
          st_next.index = req_index;
          if (req_write) begin
            // index and data settle with select low, strobe still high
            st_next.wdata = req_wdata;
            st_next.oe    = 1'b1; // gate stays high so lines are ours
            st_next.sel_n = 1'b0;
            st_next.state = ASR_WSETUP;
          end else begin
            st_next.oe     = 1'b0;
            st_next.sel_n  = 1'b0; // index already valid at this edge
            st_next.gate_n = 1'b0;
            st_next.strb_n = 1'b1;
            st_next.cnt    = cyc(RD_WAIT_CYC);
            st_next.state  = ASR_RWAIT;
          end
        end
      end
      ASR_WSETUP: begin
        // all lines valid one cycle before the second strobe falls
        st_next.strb_n = 1'b0;
        st_next.cnt    = cyc(WR_LOW_CYC);
        st_next.state  = ASR_WLOW;
      end
      ASR_WLOW: begin
        // index and data held unchanged during the whole low time
        if (last_cycle(st_reg.cnt)) begin
          st_next.strb_n = 1'b1; // strobe rise ends the write
          st_next.cnt    = CNT_ZERO;
          st_next.state  = ASR_WEND;
        end else begin
          st_next.cnt = count_down(st_reg.cnt);
        end
      end
      ASR_WEND: begin
        // data held one more cycle past the ending edge, then release
        st_next.sel_n  = 1'b1;
        st_next.oe     = 1'b0;
        st_next.rvalid = 1'b1;
        st_next.ready  = 1'b1;
        st_next.state  = ASR_IDLE;
      end
      ASR_RWAIT: begin
        if (last_cycle(st_reg.cnt)) begin
          st_next.rdata  = rd_sync;
          st_next.rvalid = 1'b1;
          st_next.sel_n  = 1'b1;
          st_next.gate_n = 1'b1;
          st_next.cnt    = cyc(TURN_CYC);
          st_next.state  = ASR_TURN;
        end else begin
          st_next.cnt = count_down(st_reg.cnt);
        end
      end
      ASR_TURN: begin
        // memory releases lines after gate rises before anyone drives
        if (last_cycle(st_reg.cnt)) begin
          st_next.cnt   = CNT_ZERO;
          st_next.ready = 1'b1;
          st_next.state = ASR_IDLE;
        end else begin
          st_next.cnt = count_down(st_reg.cnt);
        end
      end
      default: begin
        // unknown state: drop every strobe before starting over
        st_next       = park_pins(st_next);
        st_next.ready = 1'b0;
        st_next.cnt   = CNT_ZERO;
        st_next.state = ASR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_reg        <= '0;
      st_reg.state  <= ASR_IDLE;
      st_reg.sel_n  <= 1'b1;
      st_reg.gate_n <= 1'b1;
      st_reg.strb_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs, each straight from the state register
  // ****************************************************************
  // pins are registered so they all change together just after the edge
  assign req_ready     = st_reg.ready;
  assign rsp_valid     = st_reg.rvalid;
  assign rsp_rdata     = st_reg.rdata;
  assign word_index    = st_reg.index;
  assign byte_lines_o  = st_reg.wdata;
  assign byte_lines_oe = st_reg.oe;
  assign select_n      = st_reg.sel_n;
  assign gate_n        = st_reg.gate_n;
  assign strobe_n      = st_reg.strb_n;
endmodule

//--- verif/asr_ctrl_props.sv
// Purpose: pin protocol checks on the memory controller
// Assumes: one clock domain, sync reset
// Notes:   bound to every controller instance
module asr_ctrl_props (
  input wire logic                        core_clk,
  input wire logic                        nrst,
  input wire logic                        req_valid,
  input wire logic                        req_write,
  input wire logic [asr_pkg::INDEX_W-1:0] req_index,
  input wire logic [asr_pkg::BYTE_W-1:0]  req_wdata,
  input wire logic                        req_ready,
  input wire logic                        rsp_valid,
  input wire logic [asr_pkg::INDEX_W-1:0] word_index,
  input wire logic [asr_pkg::BYTE_W-1:0]  byte_lines_o,
  input wire logic                        byte_lines_oe,
  input wire logic                        select_n,
  input wire logic                        gate_n,
  input wire logic                        strobe_n
);
  import asr_pkg::*;
  // ****
  // checks
  // ****
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  chk_read_no_strobe: assert property (!select_n && !gate_n |-> strobe_n)
    else $error("strobe low in read");
  chk_no_contention: assert property (byte_lines_oe |-> gate_n)
    else $error("gate low while driving");
  chk_standby_idle: assert property (select_n |-> strobe_n && gate_n && !byte_lines_oe)
    else $error("strobe or gate active without select");
  chk_strobe_width: assert property ($fell(strobe_n) |=> strobe_n)
    else $error("strobe low width wrong");
  chk_strobe_inside: assert property (
    !strobe_n |-> !select_n && gate_n && byte_lines_oe)
    else $error("strobe low outside framed write");
  chk_bus_stable: assert property (
    !strobe_n || $rose(strobe_n) |-> $stable(word_index) && $stable(byte_lines_o))
    else $error("index or data moved in write");
  chk_write_end: assert property ($rose(strobe_n) |-> !select_n ##1 select_n)
    else $error("select not framing write end");
  chk_write_start: assert property (
    req_valid && req_ready && req_write |=> !select_n
    && word_index == $past(req_index) && byte_lines_o == $past(req_wdata))
    else $error("write pins not set up");
  chk_read_start: assert property (
    req_valid && req_ready && !req_write |=> !select_n
    && !gate_n && word_index == $past(req_index))
    else $error("read pins not set up");
  chk_write_answer: assert property (
    req_valid && req_ready && req_write |-> ##[4:5] rsp_valid)
    else $error("write answer late");
  chk_read_answer: assert property (
    req_valid && req_ready && !req_write |-> ##4 rsp_valid)
    else $error("read answer late");
endmodule
bind asr_ctrl asr_ctrl_props u_asr_ctrl_props (.core_clk, .nrst, .req_valid, .req_write,
  .req_index, .req_wdata, .req_ready, .rsp_valid, .word_index, .byte_lines_o,
  .byte_lines_oe, .select_n, .gate_n, .strobe_n);

//--- verif/asr_sram_model.sv
// Purpose: behavioural static memory at the controller pins
// Assumes: prompt access, no timing violations modelled
// Notes:   drives only while selected, gated and not writing
module asr_sram_model (
  input  wire logic [asr_pkg::INDEX_W-1:0] word_index,
  input  wire logic [asr_pkg::BYTE_W-1:0]  din,
  input  wire logic                        select_n,
  input  wire logic                        gate_n,
  input  wire logic                        strobe_n,
  output logic      [asr_pkg::BYTE_W-1:0]  dout,
  output logic                             dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import asr_pkg::*;
  logic [BYTE_W-1:0] mem [2**INDEX_W];
  logic              wr_on;
  assign wr_on = !select_n && !strobe_n;
  // store when the first of select or strobe rises
  always @(negedge wr_on) mem[word_index] = din;
  assign dout_oe = !select_n && !gate_n && strobe_n;
  assign dout = mem[word_index];
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for the memory controller
// Assumes: 100 MHz clock, inputs driven on falling edge
// Notes:   undriven bus toggles every cycle
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import asr_pkg::*;
  logic               core_clk = 0, nrst = 0, req_valid = 0, req_write = 0;
  logic [INDEX_W-1:0] req_index = '0, word_index;
  logic [BYTE_W-1:0]  req_wdata = '0, rsp_rdata, bo, m_do, bus_v, last_v = '0, q;
  logic               req_ready, rsp_valid, oe, m_oe, select_n, gate_n, strobe_n;
  int                 fails = 0, check_count = 0;
  asr_ctrl u_asr_ctrl (.core_clk, .nrst, .req_valid, .req_write, .req_index, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .word_index, .byte_lines_o(bo),
    .byte_lines_oe(oe), .byte_lines_i(bus_v), .select_n, .gate_n, .strobe_n);
  asr_sram_model u_asr_sram_model (.word_index, .din(bus_v), .select_n, .gate_n,
    .strobe_n, .dout(m_do), .dout_oe(m_oe));
  assign bus_v = oe ? bo : (m_oe ? m_do : ~last_v);
  always @(posedge core_clk) last_v <= bus_v;
  initial forever #5 core_clk = ~core_clk;
  // ****
  // tasks
  // ****
  task automatic check(input logic [INDEX_W-1:0] s, e, input string m);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic xfer(input logic w, input logic [INDEX_W-1:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    req_valid = 1;
    req_write = w;
    req_index = ix;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    @(negedge core_clk);
    req_valid = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    check(n < 40, 1, "no response");
    q = rsp_rdata;
  endtask
  task automatic rd(input logic [INDEX_W-1:0] ix, input logic [7:0] e);
    xfer(0, ix, 8'h00);
    check(q, e, "read data");
  endtask
  task automatic t_idle;
    check(select_n & strobe_n & gate_n, 1, "pins not idle");
    check(oe, 0, "bus driven at idle");
    $display("t_idle done");
  endtask
  task automatic t_edges;
    xfer(1, 17'h00000, 8'hA5);
    xfer(1, 17'h1FFFF, 8'h5A);
    xfer(1, 17'h0AAAA, 8'h3C);
    rd(17'h00000, 8'hA5);
    rd(17'h1FFFF, 8'h5A);
    rd(17'h0AAAA, 8'h3C);
    $display("t_edges done");
  endtask
  task automatic t_overwrite;
    xfer(1, 17'h00005, 8'h11);
    xfer(1, 17'h00005, 8'h22);
    rd(17'h00005, 8'h22);
    @(negedge core_clk);
    check(rsp_valid, 0, "response longer than a cycle");
    xfer(1, 17'h00006, 8'h33);
    check(rsp_rdata, 8'h22, "read byte not held");
    rd(17'h00000, 8'hA5);
    $display("t_overwrite done");
  endtask
  task automatic t_reset;
    @(negedge core_clk);
    req_valid = 1;
    req_write = 1;
    req_index = 17'h00007;
    req_wdata = 8'h77;
    @(negedge core_clk);
    req_valid = 0;
    @(negedge core_clk);
    nrst = 0;
    repeat (3) @(negedge core_clk);
    check(select_n & strobe_n & gate_n, 1, "pins active in reset");
    check(oe, 0, "bus driven in reset");
    check(req_ready | rsp_valid, 0, "handshake active in reset");
    nrst = 1;
    @(negedge core_clk);
    check(req_ready, 1, "not ready after reset");
    rd(17'h00006, 8'h33);
    $display("t_reset done");
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    nrst = 1;
    repeat (2) @(negedge core_clk);
    t_idle();
    t_edges();
    t_overwrite();
    t_reset();
    summarize();
  end
  initial begin
    #100us;
    fails++;
    summarize();
  end
endmodule
